//--- inc/dcc_pkg.sv
// Purpose: constants and types for the dual comparator control block
// Assumes: 8-bit register port, word addresses as printed
// Notes:   comparator results arrive asynchronously from the analog macro
// Operation
// - Two independent comparators, each with its own result, under one control block.
// - Comparator inputs multiplexed on port A pins zero to three per mode.
// - Internal voltage reference selectable as a comparator input source.
// - One control register at address 1Fh drives input and output multiplexers.
// - Three-bit mode field, bits two to zero, selects one of eight modes.
// - Bit 7 reads comparator 2 result, bit 6 comparator 1, read-only.
// - Control bits five and four read zero and ignore writes.
// - All implemented control bits reset to zero.
// - Direction register gates each comparator pin driver in every mode.
// - Results not valid until the mode-change settling delay has elapsed.
// - One mode drives pins three, four; pins zero, one inverting, two shared.
// - Direction register implements low five bits resetting to one; upper bits zero.
// - Any reset loads mode 000: pins zero to three analog, pin four not, comparators powered down.
// - Mode 110 passes raw comparator results to pins three and four.
// - Change flag sets on result mismatch; control access ends the mismatch.
// - Mode 010 routes the internal reference to both non-inverting inputs.
package dcc_pkg;
  localparam logic [7:0] ADDR_CTRL      = 8'h1f;
  localparam logic [7:0] ADDR_DIR       = 8'h85;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h90;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'h91;
  localparam logic [7:0] DIR_RESET      = 8'h1f;
  localparam logic [7:0] DIR_MASK       = 8'h1f;
  localparam logic [7:0] CTRL_WR_MASK   = 8'h0f;
  localparam int         BIT_C2         = 7;
  localparam int         BIT_C1         = 6;
  localparam int         BIT_SWAP       = 3;
  localparam logic [2:0] MODE_RESET     = 3'h0;
  localparam logic [2:0] MODE_TWO_COMMON = 3'h3;
  localparam logic [2:0] MODE_INT_REF   = 3'h2;
  localparam logic [2:0] MODE_PIN_OUT   = 3'h6;
  localparam logic [2:0] MODE_OFF       = 3'h7;
  localparam logic [2:0] MODE_MUX4      = 3'h1;
  localparam int         CLK_MHZ        = 125;
  localparam int         SETTLE_US      = 10;
  localparam int         SETTLE_CYC     = SETTLE_US * CLK_MHZ;
  localparam logic [10:0] SETTLE_CNT    = 11'(SETTLE_CYC);
  localparam logic [10:0] CNT_ZERO      = 11'h000;
  localparam logic [10:0] CNT_ONE       = 11'h001;

  // Analog multiplexer selects; 0 pin0,1 pin1,2 pin2,3 pin3,4 vref
  typedef struct packed {
    logic       c1_pwr;
    logic       c2_pwr;
    logic [2:0] c1_pos;
    logic [2:0] c1_neg;
    logic [2:0] c2_pos;
    logic [2:0] c2_neg;
  } dcc_route_type;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SETTLE
  } dcc_state_type;

  localparam logic [2:0] SRC_P0   = 3'h0;
  localparam logic [2:0] SRC_P1   = 3'h1;
  localparam logic [2:0] SRC_P2   = 3'h2;
  localparam logic [2:0] SRC_P3   = 3'h3;
  localparam logic [2:0] SRC_VREF = 3'h4;
endpackage

//--- rtl/dcc_top.sv
// Purpose: control and status logic around two analog comparators
// Assumes: one register access per cycle, read data valid next cycle
// Notes:   routing outputs select analog muxes; pin outputs obey direction bits
`timescale 1ns/1ps
module dcc_top
  import dcc_pkg::*;
(
  input  wire logic          core_clk_i,
  input  wire logic          reset_n_i,
  input  wire logic [7:0]    reg_addr_i,
  input  wire logic [7:0]    reg_wdata_i,
  input  wire logic          reg_wr_i,
  input  wire logic          reg_rd_i,
  output logic      [7:0]    reg_rdata_o,
  input  wire logic          cmp1_raw_i,
  input  wire logic          cmp2_raw_i,
  output dcc_route_type      route_o,
  output logic      [4:0]    pin_out_o,
  output logic      [4:0]    pin_oe_o,
  output logic      [4:0]    pin_analog_o,
  output logic               result_valid_o,
  output logic               cmp_change_flag_o,
  output logic               irq_o
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic [2:0] s1_r, s1_nxt, s2_r, s2_nxt;
  logic       cmp1_result_r, cmp1_result_nxt, cmp2_result_r, cmp2_result_nxt;

  always_comb begin
    s1_nxt          = {s1_r[1:0], cmp1_raw_i};
    s2_nxt          = {s2_r[1:0], cmp2_raw_i};
    cmp1_result_nxt = (s1_r[2] == s1_r[1]) ? s1_r[1] : cmp1_result_r;
    cmp2_result_nxt = (s2_r[2] == s2_r[1]) ? s2_r[1] : cmp2_result_r;
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      s1_r          <= 3'h0;
      s2_r          <= 3'h0;
      cmp1_result_r <= 1'b0;
      cmp2_result_r <= 1'b0;
    end else begin
      s1_r          <= s1_nxt;
      s2_r          <= s2_nxt;
      cmp1_result_r <= cmp1_result_nxt;
      cmp2_result_r <= cmp2_result_nxt;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [3:0] ctrl_r, ctrl_nxt;
  logic [4:0] dir_r, dir_nxt;
  logic [1:0] latch_r, latch_nxt;
  logic       flag_r, flag_nxt;
  logic       mask_r, mask_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic       ctrl_acc, mismatch;

  assign ctrl_acc = (reg_wr_i | reg_rd_i) && (reg_addr_i == ADDR_CTRL);
  assign mismatch = (latch_r != {cmp2_result_r, cmp1_result_r});

  always_comb begin
    ctrl_nxt  = ctrl_r;
    dir_nxt   = dir_r;
    mask_nxt  = mask_r;
    latch_nxt = latch_r;
    flag_nxt  = flag_r;
    rdata_nxt = 8'h00;
    if (reg_wr_i && reg_addr_i == ADDR_CTRL)
      ctrl_nxt = reg_wdata_i[3:0] & CTRL_WR_MASK[3:0];
    if (reg_wr_i && reg_addr_i == ADDR_DIR)
      dir_nxt = reg_wdata_i[4:0];
    if (reg_wr_i && reg_addr_i == ADDR_IRQ_MASK)
      mask_nxt = reg_wdata_i[0];
    if (reg_wr_i && reg_addr_i == ADDR_IRQ_STAT && reg_wdata_i[0])
      flag_nxt = 1'b0;
    if (ctrl_acc)
      latch_nxt = {cmp2_result_r, cmp1_result_r};
    if (mismatch)
      flag_nxt = 1'b1;
    if (reg_rd_i) begin
      case (reg_addr_i)
        ADDR_CTRL:     rdata_nxt = {cmp2_result_r, cmp1_result_r, 2'b00, ctrl_r};
        ADDR_DIR:      rdata_nxt = {3'b000, dir_r} & DIR_MASK;
        ADDR_IRQ_STAT: rdata_nxt = {7'h00, flag_r};
        ADDR_IRQ_MASK: rdata_nxt = {7'h00, mask_r};
        default:       rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      ctrl_r  <= {1'b0, MODE_RESET};
      dir_r   <= DIR_RESET[4:0];
      mask_r  <= 1'b0;
      latch_r <= 2'b00;
      flag_r  <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      ctrl_r  <= ctrl_nxt;
      dir_r   <= dir_nxt;
      mask_r  <= mask_nxt;
      latch_r <= latch_nxt;
      flag_r  <= flag_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ****************************************************************
  // Settling timer after a mode change
  // ****************************************************************
  dcc_state_type st_r, st_nxt;
  logic [10:0]   cnt_r, cnt_nxt;
  logic          mode_chg;

  assign mode_chg = (ctrl_nxt[2:0] != ctrl_r[2:0]);

  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    case (st_r)
      ST_IDLE: begin
        if (mode_chg) begin
          st_nxt  = ST_SETTLE;
          cnt_nxt = SETTLE_CNT;
        end
      end
      ST_SETTLE: begin
        if (mode_chg) begin
          cnt_nxt = SETTLE_CNT;
        end else if (cnt_r == CNT_ONE) begin
          st_nxt  = ST_IDLE;
          cnt_nxt = CNT_ZERO;
        end else begin
          cnt_nxt = cnt_r - CNT_ONE;
        end
      end
      default: begin
        st_nxt  = ST_IDLE;
        cnt_nxt = CNT_ZERO;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      st_r  <= ST_IDLE;
      cnt_r <= CNT_ZERO;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // ****************************************************************
  // Mode decode and pin control
  // ****************************************************************
  dcc_route_type route_nxt, route_r;
  logic [4:0]    pout_nxt, poe_nxt, pan_nxt;
  logic [4:0]    pout_r, poe_r, pan_r;
  logic          swap;

  assign swap = ctrl_r[BIT_SWAP];

  // Raw results go to the pins unsynchronised by intent; only a flop of delay
  always_comb begin
    route_nxt = '0;
    pout_nxt  = 5'h00;
    pan_nxt   = 5'h0f;
    case (ctrl_r[2:0])
      MODE_RESET: begin
        route_nxt = '0;
      end
      MODE_MUX4: begin
        route_nxt = '{1'b1, 1'b1, SRC_P2, swap ? SRC_P3 : SRC_P0, SRC_P2, SRC_P1};
      end
      MODE_INT_REF: begin
        route_nxt = '{1'b1, 1'b1, SRC_VREF, swap ? SRC_P3 : SRC_P0,
                      SRC_VREF, swap ? SRC_P2 : SRC_P1};
      end
      MODE_TWO_COMMON: begin
        route_nxt = '{1'b1, 1'b1, SRC_P2, SRC_P0, SRC_P2, SRC_P1};
        pan_nxt   = 5'h07;
      end
      MODE_PIN_OUT: begin
        route_nxt = '{1'b1, 1'b1, SRC_P2, SRC_P0, SRC_P2, SRC_P1};
        pout_nxt  = {cmp2_raw_i, cmp1_raw_i, 3'b000};
        pan_nxt   = 5'h07;
      end
      MODE_OFF: begin
        route_nxt = '0;
      end
      default: begin
        route_nxt = '{1'b1, 1'b1, SRC_P0, SRC_P3, SRC_P1, SRC_P2};
      end
    endcase
    poe_nxt = ~dir_r & ~pan_nxt;
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      route_r <= '0;
      pout_r  <= 5'h00;
      poe_r   <= 5'h00;
      pan_r   <= 5'h0f;
    end else begin
      route_r <= route_nxt;
      pout_r  <= pout_nxt;
      poe_r   <= poe_nxt;
      pan_r   <= pan_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  logic valid_r, irq_r;

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      valid_r <= 1'b0;
      irq_r   <= 1'b0;
    end else begin
      valid_r <= (st_nxt == ST_IDLE) && (ctrl_nxt[2:0] != MODE_RESET);
      irq_r   <= flag_nxt & mask_nxt;
    end
  end

  assign reg_rdata_o       = rdata_r;
  assign route_o           = route_r;
  assign pin_out_o         = pout_r;
  assign pin_oe_o          = poe_r;
  assign pin_analog_o      = pan_r;
  assign result_valid_o    = valid_r;
  assign cmp_change_flag_o = flag_r;
  assign irq_o             = irq_r;

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_ctrl_rd;
    reg_rd_i && reg_addr_i == ADDR_CTRL;
  endsequence
  sequence s_ctrl_wr;
    reg_wr_i && reg_addr_i == ADDR_CTRL;
  endsequence
  sequence s_stat_clr;
    reg_wr_i && reg_addr_i == ADDR_IRQ_STAT && reg_wdata_i[0];
  endsequence
  sequence s_settle_last;
    st_r == ST_SETTLE && cnt_r == CNT_ONE && !mode_chg;
  endsequence

  chk_ctrl_readback: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    s_ctrl_rd |=> reg_rdata_o[5:4] == 2'b00 && reg_rdata_o[3:0] == $past(ctrl_r))
    else $error("control readback wrong");
  chk_result_bits: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    s_ctrl_rd |=> reg_rdata_o[7:6] == {$past(cmp2_result_r), $past(cmp1_result_r)})
    else $error("result bits wrong");
  chk_dir_upper: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    reg_rd_i && reg_addr_i == ADDR_DIR |=> reg_rdata_o[7:5] == 3'b000)
    else $error("direction upper bits nonzero");
  chk_oe_gated: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (pin_oe_o & pin_analog_o) == 5'h00)
    else $error("analog pin driven");
  chk_flag_set: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    mismatch |=> cmp_change_flag_o)
    else $error("change flag missed");
  chk_flag_clear: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    s_stat_clr ##0 !mismatch |=> !cmp_change_flag_o)
    else $error("change flag not cleared");
  chk_mismatch_end: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    ctrl_acc |=> latch_r == {$past(cmp2_result_r), $past(cmp1_result_r)})
    else $error("mismatch not ended");
  chk_settle_wait: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    mode_chg |=> !result_valid_o [*8])
    else $error("valid too soon");
  chk_settle_done: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    s_settle_last |=> result_valid_o || ctrl_r[2:0] == MODE_RESET)
    else $error("valid not raised after settling");
  chk_settle_range: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    st_r == ST_SETTLE |-> cnt_r != CNT_ZERO && cnt_r <= SETTLE_CNT)
    else $error("settle counter out of range");
  chk_pin_mode: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    ctrl_r[2:0] == MODE_PIN_OUT |=> pin_out_o[4:3] == {$past(cmp2_raw_i), $past(cmp1_raw_i)})
    else $error("pin output mismatch");
  chk_off_power: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    ctrl_r[2:0] == MODE_OFF || ctrl_r[2:0] == MODE_RESET |=> !route_o.c1_pwr && !route_o.c2_pwr)
    else $error("comparator powered in off mode");
  chk_vref_route: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    ctrl_r[2:0] == MODE_INT_REF |=> route_o.c1_pos == SRC_VREF && route_o.c2_pos == SRC_VREF)
    else $error("reference not routed");
  chk_swap_route: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    ctrl_r[2:0] == MODE_INT_REF && ctrl_r[BIT_SWAP] |=> route_o.c1_neg == SRC_P3)
    else $error("swapped input not routed");
  chk_ctrl_write: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    s_ctrl_wr |=> {4'h0, ctrl_r} == ($past(reg_wdata_i) & CTRL_WR_MASK))
    else $error("control write not taken");
  chk_dir_write: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    reg_wr_i && reg_addr_i == ADDR_DIR |=> {3'b000, dir_r} == ($past(reg_wdata_i) & DIR_MASK))
    else $error("direction write not taken");
  chk_reset_mode: assert property (@(posedge core_clk_i)
    !reset_n_i |=> ctrl_r == 4'h0 && dir_r == DIR_RESET[4:0])
    else $error("reset values wrong");
  chk_irq_mask: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    !mask_r && !mask_nxt |=> !irq_o)
    else $error("masked interrupt raised");
  chk_irq_level: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    irq_o == (cmp_change_flag_o & mask_r))
    else $error("interrupt level wrong");
endmodule

//--- testbench/dcc_analog_model.sv
// Purpose: analog comparator pair on the far side of the control block
// Assumes: pin and reference levels are abstract 8-bit voltages from the bench
// Notes:   a powered-down comparator reads low
`timescale 1ns/1ps
module dcc_analog_model
  import dcc_pkg::*;
(
  input  wire dcc_route_type       route_i,
  input  wire logic [4:0][7:0]     lvl_i,
  output logic                     cmp1_o,
  output logic                     cmp2_o
);
  // Index 4 is the internal reference, 0 to 3 the port A pins
  assign cmp1_o = route_i.c1_pwr & (lvl_i[route_i.c1_pos] > lvl_i[route_i.c1_neg]);
  assign cmp2_o = route_i.c2_pwr & (lvl_i[route_i.c2_pos] > lvl_i[route_i.c2_neg]);
endmodule

//--- testbench/dcc_top_test.sv
// Purpose: self-checking bench for the dual comparator control block
// Assumes: analog side modelled by dcc_analog_model
// Notes:   results take a few cycles to cross the synchroniser
`timescale 1ns/1ps
module dcc_top_test;
  import dcc_pkg::*;
  logic            clk = 0;
  logic            rst_n = 0;
  logic [7:0]      addr = 0;
  logic [7:0]      wdata = 0;
  logic            wr = 0;
  logic            rd = 0;
  logic [7:0]      rdata;
  logic            c1;
  logic            c2;
  dcc_route_type   route;
  logic [4:0]      pout;
  logic [4:0]      poe;
  logic [4:0]      pan;
  logic            valid;
  logic            flag;
  logic            irq;
  logic [4:0][7:0] lvl = {8'h28, 8'h05, 8'h14, 8'h1e, 8'h0a};
  int              num_errors = 0;
  int              num_checks = 0;
  int              cnt;
  logic [7:0]      d;
  // Row: control write value, then expected low nibble on read back
  logic [15:0]     rows [10] = '{16'h0000, 16'h0909, 16'h0202, 16'h0a0a, 16'h0303,
                                 16'h0404, 16'h0505, 16'h0606, 16'h0707, 16'hff0f};

  always #4 clk = ~clk;

  dcc_top dut (.core_clk_i(clk), .reset_n_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .cmp1_raw_i(c1), .cmp2_raw_i(c2),
    .route_o(route), .pin_out_o(pout), .pin_oe_o(poe), .pin_analog_o(pan),
    .result_valid_o(valid), .cmp_change_flag_o(flag), .irq_o(irq));
  dcc_analog_model analog (.route_i(route), .lvl_i(lvl), .cmp1_o(c1), .cmp2_o(c2));

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic rreg(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask

  task automatic conclude();
    if (num_errors == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    #100000;
    num_errors++;
    conclude();
  end

  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    // ********************
    // Mode table
    // ********************
    foreach (rows[i]) begin
      wreg(ADDR_CTRL, rows[i][15:8]);
      repeat (8) @(posedge clk);
      rreg(ADDR_CTRL, d);
      chk("ctrl", {c2, c1, 2'b00, rows[i][3:0]}, d);
    end
    // ********************
    // Direction, settling, routing
    // ********************
    wreg(ADDR_DIR, 8'hff);
    rreg(ADDR_DIR, d);
    chk("dir_hi", 8'h1f, d);
    wreg(ADDR_DIR, 8'h07);
    wreg(ADDR_CTRL, 8'h03);
    @(negedge clk);
    cnt = 1;
    while (valid !== 1'b1 && cnt < 2000) begin
      @(negedge clk);
      cnt++;
    end
    chk("settle", 8'h01, {7'h0, (cnt >= SETTLE_CYC - 2 && cnt <= SETTLE_CYC + 2)});
    chk("oe3", 8'h18, {3'h0, poe});
    chk("an3", 8'h07, {5'h0, pan[2:0]});
    chk("c1n", {5'h0, SRC_P0}, {5'h0, route.c1_neg});
    chk("c2n", {5'h0, SRC_P1}, {5'h0, route.c2_neg});
    chk("c2p", {5'h0, SRC_P2}, {5'h0, route.c2_pos});
    // ********************
    // Change flag and interrupt
    // ********************
    rreg(ADDR_CTRL, d);
    wreg(ADDR_IRQ_STAT, 8'h01);
    wreg(ADDR_IRQ_MASK, 8'h01);
    @(negedge clk);
    chk("flag_clr", 8'h00, {7'h0, flag});
    lvl[2] <= 8'h00;
    repeat (8) @(posedge clk);
    @(negedge clk);
    chk("irq_set", 8'h03, {6'h0, irq, flag});
    wreg(ADDR_IRQ_STAT, 8'h01);
    repeat (2) @(posedge clk);
    chk("flag_hold", 8'h01, {7'h0, flag});
    rreg(ADDR_CTRL, d);
    wreg(ADDR_IRQ_STAT, 8'h01);
    @(negedge clk);
    chk("flag_end", 8'h00, {6'h0, irq, flag});
    lvl[2] <= 8'h14;
    repeat (8) @(posedge clk);
    wreg(ADDR_IRQ_MASK, 8'h00);
    @(negedge clk);
    chk("irq_mask", 8'h01, {6'h0, irq, flag});
    // ********************
    // Reference and swap, pin outputs
    // ********************
    wreg(ADDR_CTRL, 8'h0a);
    @(negedge clk);
    chk("valid_drop", 8'h00, {7'h0, valid});
    @(negedge clk);
    chk("vref", {2'h0, SRC_VREF, SRC_VREF}, {2'h0, route.c1_pos, route.c2_pos});
    chk("swap", {5'h0, SRC_P3}, {5'h0, route.c1_neg});
    wreg(ADDR_DIR, 8'h17);
    wreg(ADDR_CTRL, 8'h06);
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("oe6", 8'h01, {6'h0, poe[4:3]});
    chk("out6", {6'h0, c2, c1}, {6'h0, pout[4:3]});
    rreg(8'h40, d);
    chk("unmapped", 8'h00, d);
    // ********************
    // Reset in mid-run
    // ********************
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk("an_rst", 8'h0f, {3'h0, pan});
    chk("pwr_rst", 8'h00, {6'h0, route.c1_pwr, route.c2_pwr});
    rreg(ADDR_CTRL, d);
    chk("ctrl_rst", 8'h00, d);
    rreg(ADDR_DIR, d);
    chk("dir_rst", 8'h1f, d);
    conclude();
  end
endmodule
